// File: hdl/wincmp_pkg.sv
// package: constants and carriers for the window compare alert capture block
package wincmp_pkg;
  localparam int DATA_W    = 12;
  localparam int CNT_W     = 4;
  localparam int HYS_W     = 6;
  localparam int CHID_W    = 4;
  localparam int NUM_CH    = 2;
  localparam int BUF_DEPTH = 16;
  localparam int PTR_W     = 4;

  localparam logic [DATA_W-1:0] CODE_FULL = 12'h0FFF;
  localparam logic [DATA_W-1:0] CODE_ZERO = 12'h0000;
  localparam logic [CHID_W-1:0] CHID_FIRST  = 4'h0;
  localparam logic [CHID_W-1:0] CHID_SECOND = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_RESET = 4'h0;
  localparam logic [PTR_W-1:0]  PTR_RESET = 4'h0;
  localparam logic [PTR_W-1:0]  PTR_LAST  = 4'hF;

  typedef enum logic [2:0] {
    CAP_RUN  = 3'b001,
    CAP_POST = 3'b010,
    CAP_DONE = 3'b100
  } cap_state_e;

  typedef enum logic {
    MODE_BEFORE = 1'b0,
    MODE_AFTER  = 1'b1
  } cap_mode_e;

  typedef struct packed {
    logic [DATA_W-1:0] low_thresh;
    logic [DATA_W-1:0] high_thresh;
    logic [HYS_W-1:0]  hysteresis;
  } ch_cfg_s;

  typedef struct packed {
    logic              valid;
    logic              channel;
    logic [DATA_W-1:0] code;
  } sample_s;

  typedef struct packed {
    logic [NUM_CH-1:0] low_clr;
    logic [NUM_CH-1:0] high_clr;
  } flag_clr_s;
endpackage

// File: hdl/window_compare_alert_capture.sv
// window comparator with event counter, alert, flags and sample buffer
`timescale 1ns/1ps
module window_compare_alert_capture #(
  parameter int DEPTH = wincmp_pkg::BUF_DEPTH
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RST,
  input  wire wincmp_pkg::sample_s           SAMPLE,
  input  wire wincmp_pkg::ch_cfg_s           CFG_FIRST,
  input  wire wincmp_pkg::ch_cfg_s           CFG_SECOND,
  input  wire logic [wincmp_pkg::CNT_W-1:0]  CONSECUTIVE_TRIP_COUNT,
  input  wire wincmp_pkg::cap_mode_e         CAPTURE_MODE,
  input  wire logic                          REARM,
  input  wire wincmp_pkg::flag_clr_s         FLAG_CLEAR,
  input  wire logic [wincmp_pkg::PTR_W-1:0]  BUF_RD_ADDR,
  output logic                               ALERT,
  output logic                               LOW_TRIP_FLAG_FIRST,
  output logic                               LOW_TRIP_FLAG_SECOND,
  output logic                               HIGH_TRIP_FLAG_FIRST,
  output logic                               HIGH_TRIP_FLAG_SECOND,
  output logic [wincmp_pkg::CHID_W-1:0]      FIRST_TRIP_CHANNEL,
  output logic [wincmp_pkg::DATA_W-1:0]      BUF_RD_DATA,
  output logic                               CAPTURE_DONE
);
  import wincmp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (DEPTH != BUF_DEPTH) begin : g_depth_bad
    $error("buffer depth must be sixteen");
  end
  if (DEPTH != (1 << PTR_W)) begin : g_ptr_bad
    $error("pointer width must cover the buffer exactly");
  end
  if (PTR_LAST != PTR_W'(DEPTH - 1)) begin : g_last_bad
    $error("last pointer value must be the final slot");
  end
  if (NUM_CH != 2) begin : g_ch_bad
    $error("exactly two channels are served");
  end
  if (HYS_W > DATA_W) begin : g_hys_wide
    $error("hysteresis wider than the code");
  end
  if (HYS_W < 1) begin : g_hys_narrow
    $error("hysteresis field too narrow");
  end
  if (CHID_W < 1) begin : g_chid_bad
    $error("channel id field too narrow");
  end
  if (CHID_FIRST == CHID_SECOND) begin : g_chid_same
    $error("channel id codes must differ");
  end
  if (CNT_W < 1) begin : g_cnt_bad
    $error("event count field too narrow");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [NUM_CH-1:0]            low_flag;
    logic [NUM_CH-1:0]            high_flag;
    logic [NUM_CH-1:0]            low_arm;
    logic [NUM_CH-1:0]            high_arm;
    logic [NUM_CH-1:0][CNT_W:0]   run_cnt;
    logic                         alert;
    logic [CHID_W-1:0]            chid;
    cap_state_e                   cap;
    logic [PTR_W-1:0]             wr_ptr;
    logic [PTR_W-1:0]             post_cnt;
    logic [DATA_W-1:0]            rd_data;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [DATA_W-1:0] buf_mem [DEPTH];
  logic              buf_we;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // low comparator with hysteresis: once set, stays until code > low + hys
  function automatic logic low_cmp(input logic [DATA_W-1:0] code,
                                   input ch_cfg_s cfg,
                                   input logic armed);
    logic [DATA_W:0] lim;
    lim = {1'b0, cfg.low_thresh} + {{(DATA_W+1-HYS_W){1'b0}}, cfg.hysteresis};
    if (armed) begin
      low_cmp = ({1'b0, code} <= lim);
    end else begin
      low_cmp = (code <= cfg.low_thresh);
    end
  endfunction

  // high comparator with hysteresis: once set, stays until code < high - hys
  function automatic logic high_cmp(input logic [DATA_W-1:0] code,
                                    input ch_cfg_s cfg,
                                    input logic armed);
    logic [DATA_W:0] lim;
    lim = {1'b0, cfg.high_thresh} - {{(DATA_W+1-HYS_W){1'b0}}, cfg.hysteresis};
    if (armed) begin
      high_cmp = lim[DATA_W] || ({1'b0, code} >= lim);
    end else begin
      high_cmp = (code >= cfg.high_thresh);
    end
  endfunction

  // next write position; wraps so the buffer overwrites its oldest entry
  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] ptr);
    ptr_next = ptr + {{(PTR_W-1){1'b0}}, 1'b1};
  endfunction

  // buffer slot for a read address; address zero is the oldest entry
  function automatic logic [PTR_W-1:0] rd_slot(input logic [PTR_W-1:0] base,
                                               input logic [PTR_W-1:0] ofs);
    rd_slot = base + ofs;
  endfunction

  // run counter step, saturating at the required length
  function automatic logic [CNT_W:0] run_next(input logic [CNT_W:0] run,
                                              input logic [CNT_W:0] req);
    if (run < req) begin
      run_next = run + {{CNT_W{1'b0}}, 1'b1};
    end else begin
      run_next = run;
    end
  endfunction

  // true when this hit completes the required run
  function automatic logic run_met(input logic [CNT_W:0] run,
                                   input logic [CNT_W:0] req);
    run_met = (run + {{CNT_W{1'b0}}, 1'b1}) >= req;
  endfunction

  // channel number to the recorded id code
  function automatic logic [CHID_W-1:0] chid_of(input logic ch);
    if (ch) begin
      chid_of = CHID_SECOND;
    end else begin
      chid_of = CHID_FIRST;
    end
  endfunction

  // configuration of the channel a sample belongs to
  function automatic ch_cfg_s cfg_of(input logic ch);
    if (ch) begin
      cfg_of = CFG_SECOND;
    end else begin
      cfg_of = CFG_FIRST;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  logic [NUM_CH-1:0] lo_hit;
  logic [NUM_CH-1:0] hi_hit;
  logic [NUM_CH-1:0] trip;
  logic [CNT_W:0]    need;
  logic              trip_now;
  ch_cfg_s           cfg_sel;

  always_comb begin
    s_d      = s_q;
    lo_hit   = '0;
    hi_hit   = '0;
    trip     = '0;
    buf_we   = 1'b0;
    trip_now = 1'b0;
    cfg_sel  = cfg_of(SAMPLE.channel);
    need     = {1'b0, CONSECUTIVE_TRIP_COUNT} + {{CNT_W{1'b0}}, 1'b1};
    s_d.low_flag  = s_q.low_flag & ~FLAG_CLEAR.low_clr;
    s_d.high_flag = s_q.high_flag & ~FLAG_CLEAR.high_clr;
    if (SAMPLE.valid) begin
      lo_hit[SAMPLE.channel] = low_cmp(SAMPLE.code, cfg_sel,
                                       s_q.low_arm[SAMPLE.channel]);
      hi_hit[SAMPLE.channel] = high_cmp(SAMPLE.code, cfg_sel,
                                        s_q.high_arm[SAMPLE.channel]);
      s_d.low_arm[SAMPLE.channel]  = lo_hit[SAMPLE.channel];
      s_d.high_arm[SAMPLE.channel] = hi_hit[SAMPLE.channel];
      // per channel run of out-of-window conversions
      if (lo_hit[SAMPLE.channel] || hi_hit[SAMPLE.channel]) begin
        s_d.run_cnt[SAMPLE.channel] = run_next(s_q.run_cnt[SAMPLE.channel],
                                               need);
        if (run_met(s_q.run_cnt[SAMPLE.channel], need)) begin
          trip[SAMPLE.channel] = 1'b1;
        end
      end else begin
        s_d.run_cnt[SAMPLE.channel] = '0;
      end
      if (trip[SAMPLE.channel]) begin
        // set wins over a clear in the same cycle
        if (lo_hit[SAMPLE.channel]) begin
          s_d.low_flag[SAMPLE.channel] = 1'b1;
        end
        if (hi_hit[SAMPLE.channel]) begin
          s_d.high_flag[SAMPLE.channel] = 1'b1;
        end
        if (!s_q.alert) begin
          trip_now  = 1'b1;
          s_d.alert = 1'b1;
          s_d.chid  = chid_of(SAMPLE.channel);
        end
      end
      // sample buffer capture
      unique case (s_q.cap)
        CAP_RUN: begin
          if (CAPTURE_MODE == MODE_BEFORE) begin
            buf_we     = 1'b1;
            s_d.wr_ptr = ptr_next(s_q.wr_ptr);
            if (trip_now) begin
              s_d.cap = CAP_DONE;
            end
          end else if (trip_now) begin
            buf_we       = 1'b1;
            s_d.wr_ptr   = ptr_next(s_q.wr_ptr);
            s_d.post_cnt = PTR_RESET;
            s_d.cap      = CAP_POST;
          end
        end
        CAP_POST: begin
          buf_we       = 1'b1;
          s_d.wr_ptr   = ptr_next(s_q.wr_ptr);
          s_d.post_cnt = ptr_next(s_q.post_cnt);
          if (s_q.post_cnt == PTR_LAST - 4'h1) begin
            s_d.cap = CAP_DONE;
          end
        end
        CAP_DONE: begin
        end
        default: s_d.cap = CAP_RUN;
      endcase
    end
    // oldest entry sits at wr_ptr once capture stops; index 0 is oldest
    s_d.rd_data = buf_mem[rd_slot(s_q.wr_ptr, BUF_RD_ADDR)];
    // flags are left for the host to clear
    if (REARM) begin
      s_d.post_cnt = PTR_RESET;
      s_d.alert    = 1'b0;
      s_d.cap      = CAP_RUN;
      s_d.run_cnt  = '0;
      s_d.low_arm  = '0;
      s_d.high_arm = '0;
      s_d.chid     = CHID_FIRST;
      s_d.wr_ptr   = PTR_RESET;
      buf_we       = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      s_q.low_flag  <= '0;
      s_q.high_flag <= '0;
      s_q.low_arm   <= '0;
      s_q.high_arm  <= '0;
      s_q.run_cnt   <= '0;
      s_q.alert     <= 1'b0;
      s_q.chid      <= CHID_FIRST;
      s_q.cap       <= CAP_RUN;
      s_q.wr_ptr    <= PTR_RESET;
      s_q.post_cnt  <= PTR_RESET;
      s_q.rd_data   <= CODE_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (buf_we) begin
      buf_mem[s_q.wr_ptr] <= SAMPLE.code;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ALERT                 = s_q.alert;
  assign LOW_TRIP_FLAG_FIRST   = s_q.low_flag[0];
  assign LOW_TRIP_FLAG_SECOND  = s_q.low_flag[1];
  assign HIGH_TRIP_FLAG_FIRST  = s_q.high_flag[0];
  assign HIGH_TRIP_FLAG_SECOND = s_q.high_flag[1];
  assign FIRST_TRIP_CHANNEL    = s_q.chid;
  assign BUF_RD_DATA           = s_q.rd_data;
  assign CAPTURE_DONE          = (s_q.cap == CAP_DONE);
endmodule

// File: test/wincmp_props.sv
// checker: alert, flag and capture relations at the block ports
`timescale 1ns/1ps
module wincmp_props (
  input wire logic                  SYS_CLK,
  input wire logic                  RST,
  input wire wincmp_pkg::sample_s   SAMPLE,
  input wire wincmp_pkg::ch_cfg_s   CFG_SECOND,
  input wire logic [3:0]            CONSECUTIVE_TRIP_COUNT,
  input wire wincmp_pkg::cap_mode_e CAPTURE_MODE,
  input wire logic                  REARM,
  input wire wincmp_pkg::flag_clr_s FLAG_CLEAR,
  input wire logic                  ALERT,
  input wire logic                  LOW_TRIP_FLAG_FIRST,
  input wire logic                  LOW_TRIP_FLAG_SECOND,
  input wire logic                  HIGH_TRIP_FLAG_FIRST,
  input wire logic                  HIGH_TRIP_FLAG_SECOND,
  input wire logic [3:0]            FIRST_TRIP_CHANNEL,
  input wire logic                  CAPTURE_DONE
);
  import wincmp_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  wire s1 = SAMPLE.valid && SAMPLE.channel && CONSECUTIVE_TRIP_COUNT == 4'h0;
  sequence s_trip;
    $rose(ALERT);
  endsequence
  a_low_flag_set:
    assert property (s1 && SAMPLE.code <= CFG_SECOND.low_thresh
      |=> LOW_TRIP_FLAG_SECOND) else $error("low flag missed");
  a_high_flag_set:
    assert property (s1 && SAMPLE.code >= CFG_SECOND.high_thresh
      |=> HIGH_TRIP_FLAG_SECOND) else $error("high flag missed");
  a_flag_holds:
    assert property (LOW_TRIP_FLAG_FIRST && !FLAG_CLEAR.low_clr[0]
      |=> LOW_TRIP_FLAG_FIRST) else $error("flag dropped");
  a_flag_clears:
    assert property (FLAG_CLEAR.high_clr[1]
      && !(SAMPLE.valid && SAMPLE.channel)
      |=> !HIGH_TRIP_FLAG_SECOND) else $error("flag not cleared");
  a_alert_holds:
    assert property (ALERT && !REARM |=> ALERT) else $error("alert dropped");
  a_alert_cause:
    assert property (s_trip |-> $past(SAMPLE.valid)) else $error("alert cause");
  a_trip_channel:
    assert property (s_trip
      |-> FIRST_TRIP_CHANNEL == {3'h0, $past(SAMPLE.channel)})
      else $error("wrong channel");
  a_trip_flag:
    assert property (s_trip |-> LOW_TRIP_FLAG_FIRST || LOW_TRIP_FLAG_SECOND
      || HIGH_TRIP_FLAG_FIRST || HIGH_TRIP_FLAG_SECOND) else $error("no flag");
  a_before_stop:
    assert property (s_trip and CAPTURE_MODE == MODE_BEFORE |-> CAPTURE_DONE)
      else $error("capture not stopped");
  a_rearm_clear:
    assert property (REARM && !SAMPLE.valid |=> !ALERT
      && FIRST_TRIP_CHANNEL == 4'h0) else $error("rearm failed");
endmodule
bind window_compare_alert_capture wincmp_props u_props (.SYS_CLK(SYS_CLK),
  .RST(RST), .SAMPLE(SAMPLE), .CFG_SECOND(CFG_SECOND),
  .CONSECUTIVE_TRIP_COUNT(CONSECUTIVE_TRIP_COUNT), .REARM(REARM),
  .CAPTURE_MODE(CAPTURE_MODE), .FLAG_CLEAR(FLAG_CLEAR), .ALERT(ALERT),
  .LOW_TRIP_FLAG_FIRST(LOW_TRIP_FLAG_FIRST), .CAPTURE_DONE(CAPTURE_DONE),
  .LOW_TRIP_FLAG_SECOND(LOW_TRIP_FLAG_SECOND),
  .HIGH_TRIP_FLAG_FIRST(HIGH_TRIP_FLAG_FIRST),
  .HIGH_TRIP_FLAG_SECOND(HIGH_TRIP_FLAG_SECOND),
  .FIRST_TRIP_CHANNEL(FIRST_TRIP_CHANNEL));

// File: test/wincmp_host.sv
// host model: clears all flags and rearms after an alert
`timescale 1ns/1ps
module wincmp_host (
  input wire logic        clk,
  input wire logic        en,
  input wire logic [3:0]  wait_cycles,
  input wire logic        alert,
  output logic            rearm,
  output wincmp_pkg::flag_clr_s flag_clear
);
  import wincmp_pkg::*;
  logic [3:0] cnt = 4'h0;
  initial rearm = 1'b0;
  initial flag_clear = '0;
  always @(negedge clk) begin
    rearm <= 1'b0;
    flag_clear <= '0;
    cnt <= 4'h0;
    if (en && alert && cnt == wait_cycles) begin
      rearm <= 1'b1;
      flag_clear <= '1;
    end else if (en && alert) begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// File: test/test_window_compare_alert_capture.sv
// testbench: window compare alert capture
`timescale 1ns/1ps
module test_window_compare_alert_capture;
  import wincmp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sample_s smp = '0;
  ch_cfg_s c0 = '0;
  ch_cfg_s c1 = '0;
  logic [3:0] cnt = 4'h0;
  cap_mode_e mode = MODE_BEFORE;
  logic host_en = 1'b0;
  logic [3:0] dly = 4'h9;
  logic [3:0] rd_addr = 4'h0;
  logic rearm, alert, lf0, lf1, hf0, hf1, done;
  flag_clr_s fclr;
  logic [3:0] chid;
  logic [11:0] rd_data;
  logic [11:0] q[$];
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'h2e9f3802;
  always #2 clk = ~clk;
  window_compare_alert_capture uut (.SYS_CLK(clk), .RST(rst), .SAMPLE(smp),
    .CFG_FIRST(c0), .CFG_SECOND(c1), .CONSECUTIVE_TRIP_COUNT(cnt),
    .CAPTURE_MODE(mode), .REARM(rearm), .FLAG_CLEAR(fclr),
    .BUF_RD_ADDR(rd_addr), .ALERT(alert), .LOW_TRIP_FLAG_FIRST(lf0),
    .LOW_TRIP_FLAG_SECOND(lf1), .HIGH_TRIP_FLAG_FIRST(hf0),
    .HIGH_TRIP_FLAG_SECOND(hf1), .FIRST_TRIP_CHANNEL(chid),
    .BUF_RD_DATA(rd_data), .CAPTURE_DONE(done));
  wincmp_host host (.clk(clk), .en(host_en), .wait_cycles(dly),
    .alert(alert), .rearm(rearm), .flag_clear(fclr));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [11:0] rnd(input int lo, input int hi);
    return 12'(lo + ($unsigned($random(seed)) % (hi - lo + 1)));
  endfunction
  function automatic logic [11:0] flags();
    return {6'h00, done, alert, lf0, lf1, hf0, hf1};
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic ch, input logic [11:0] code, input bit keep);
    @(negedge clk);
    smp = '{1'b1, ch, code};
    if (keep) q.push_back(code);
    if (q.size() > 16) void'(q.pop_front());
  endtask
  task automatic idle();
    @(negedge clk);
    smp.valid = 1'b0;
  endtask
  task automatic rdbuf();
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      rd_addr = i[3:0];
      @(negedge clk);
      chk(rd_data, q[i]);
    end
  endtask
  task automatic host_wake();
    host_en = 1'b1;
    for (int i = 0; i < 30 && alert; i++) @(negedge clk);
    @(negedge clk);
    chk(flags(), 12'h000);
    host_en = 1'b0;
  endtask
  task automatic complete_run();
    if (err_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    c0 = '{12'h064, 12'hBB8, 6'h00};
    c1 = '{CODE_ZERO, CODE_FULL, 6'h00};
    cnt = 4'h2;
    for (int i = 0; i < 20; i++) send(i[0], rnd(101, 2999), 1);
    send(0, 12'h064, 1);
    send(0, rnd(0, 99), 1);
    send(0, 12'h065, 1);
    idle();
    chk(flags(), 12'h000);
    send(0, rnd(0, 99), 1);
    send(1, rnd(1, 4094), 1);
    send(0, 12'h064, 1);
    send(1, rnd(1, 4094), 1);
    send(0, CODE_ZERO, 1);
    idle();
    chk(flags(), 12'h038);
    chk({8'h00, chid}, {8'h00, CHID_FIRST});
    send(0, rnd(101, 2999), 0);
    idle();
    rdbuf();
    host_wake();
    mode = MODE_AFTER;
    cnt = 4'h0;
    dly = 4'h0;
    send(1, 12'hFFE, 0);
    send(1, 12'h001, 0);
    send(0, rnd(101, 2999), 0);
    idle();
    chk(flags(), 12'h000);
    q.delete();
    send(1, CODE_FULL, 1);
    for (int i = 0; i < 14; i++) send(i[0], rnd(101, 2999), 1);
    idle();
    chk(flags(), 12'h011);
    chk({8'h00, chid}, {8'h00, CHID_SECOND});
    send(1, rnd(1, 4094), 1);
    idle();
    chk(flags(), 12'h031);
    send(1, CODE_ZERO, 0);
    idle();
    chk(flags(), 12'h035);
    rdbuf();
    host_wake();
    complete_run();
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
